/* File: hdl/espo_top.sv */
// sync pulse output block with axi4-lite register slave
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
module espo_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_reading_done,
  input  wire logic        i_integ_done,
  input  wire logic        i_aperture,
  input  wire logic        i_prog_done,
  input  wire logic [6:0]  i_status_evt,
  input  wire logic        i_ext_trig,
  input  wire logic        i_rdg_busy,
  output logic             o_trig_start,
  output logic             o_sync_out,
  output logic             o_irq
);
  // ==========================================
  // helpers
  // true for every implemented offset
  function automatic logic espo_mapped(input logic [7:0] a);
    return a == espo_pkg::OFS_CFG     || a == espo_pkg::OFS_GROUP ||
           a == espo_pkg::OFS_REQMASK || a == espo_pkg::OFS_REQSTAT ||
           a == espo_pkg::OFS_CLRSTAT || a == espo_pkg::OFS_ISTAT ||
           a == espo_pkg::OFS_IMASK;
  endfunction
  // byte-lane merge of a write into an old value
  function automatic logic [31:0] espo_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // state
  espo_pkg::espo_cfg_s cfg_reg;       // sync_output_config
  logic [15:0]         grp_size_reg;  // readings_per_trigger
  logic [15:0]         grp_cnt_reg;   // readings in this group
  logic [7:0]          req_mask_reg;  // request_enable_mask
  logic [7:0]          stat_bits_reg; // sticky status events
  logic                req_bit_reg;   // service request bit
  logic [2:0]          ists_reg;      // interrupt status
  logic [2:0]          imask_reg;     // interrupt mask
  espo_pkg::espo_pst_e pst_reg;       // pulse timer state
  logic [7:0]          pcnt_reg;      // pulse cycle count
  logic                pend_reg;      // event seen mid-pulse
  logic                held_reg;      // buffered trigger
  logic                aw_rdy_reg;
  logic                w_rdy_reg;
  logic [7:0]          awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                ar_rdy_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;
  logic                sync_reg;
  logic                trig_reg;
  logic                irq_reg;

  // ==========================================
  // write decode
  logic        wr_fire;    // both halves captured
  logic [31:0] wr_val;     // merged write data
  logic        wr_cfg;
  logic        wr_clr;
  logic [31:0] cfg_word;
  assign wr_fire  = !aw_rdy_reg && !w_rdy_reg && !bvalid_reg;
  assign cfg_word = {27'h0, cfg_reg};
  assign wr_cfg   = wr_fire && awaddr_reg == espo_pkg::OFS_CFG;
  // clear only on a written one in bit 0
  assign wr_clr   = wr_fire && awaddr_reg == espo_pkg::OFS_CLRSTAT
                    && wstrb_reg[0] && wdata_reg[0];
  assign wr_val   = espo_merge(cfg_word, wdata_reg, wstrb_reg);

  // ==========================================
  // event sources
  logic       grp_last;   // last reading of a group
  logic [7:0] evt_vec;    // status events, bit 0 program done
  logic       sreq_fire;  // enabled status event this cycle
  logic       evt_sel;    // selected source event
  logic       too_fast;   // trigger refused
  logic [15:0] grp_goal;
  // zero group size behaves as one reading
  assign grp_goal = (grp_size_reg == 16'h0) ? 16'h1 : grp_size_reg;
  assign grp_last = i_reading_done
                    && (grp_cnt_reg + 16'h1 >= grp_goal);
  assign evt_vec  = {i_status_evt, i_prog_done};
  // every enabled occurrence fires, bit level irrelevant
  assign sreq_fire = |(evt_vec & req_mask_reg);

  // source mux; reading strobe is one per computed result,
  // sampled ac internal samples never reach it
  always_comb begin
    unique case (cfg_reg.src)
      espo_pkg::SRC_READING:  evt_sel = i_reading_done;
      espo_pkg::SRC_GROUP:    evt_sel = grp_last;
      espo_pkg::SRC_INTEG:    evt_sel = i_integ_done;
      espo_pkg::SRC_SREQ:     evt_sel = sreq_fire;
      espo_pkg::SRC_ONE_SHOT: evt_sel = 1'b1;
      default:                evt_sel = 1'b0;
    endcase
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cfg_reg <= espo_pkg::CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg <= espo_pkg::espo_cfg_s'(wr_val[4:0]);
    end else if (cfg_reg.src == espo_pkg::SRC_ONE_SHOT) begin
      // one event issued, then the output is disabled
      cfg_reg.src <= espo_pkg::SRC_OFF;
    end
  end

  // group size, request mask and interrupt mask
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      grp_size_reg <= espo_pkg::GROUP_RST;
      req_mask_reg <= 8'h00;
      imask_reg    <= 3'h0;
    end else if (wr_fire) begin
      if (awaddr_reg == espo_pkg::OFS_GROUP) begin
        grp_size_reg <= 16'(espo_merge({16'h0, grp_size_reg},
                                       wdata_reg, wstrb_reg));
      end
      if (awaddr_reg == espo_pkg::OFS_REQMASK && wstrb_reg[0]) begin
        req_mask_reg <= wdata_reg[7:0];
      end
      if (awaddr_reg == espo_pkg::OFS_IMASK && wstrb_reg[0]) begin
        imask_reg <= wdata_reg[2:0];
      end
    end
  end

  // ==========================================
  // group counter, runs whatever the source
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      grp_cnt_reg <= 16'h0;
    end else if (grp_last) begin
      grp_cnt_reg <= 16'h0;
    end else if (i_reading_done) begin
      grp_cnt_reg <= grp_cnt_reg + 16'h1;
    end
  end

  // ==========================================
  // status bits and request bit, set beats clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stat_bits_reg <= 8'h00;
      req_bit_reg   <= 1'b0;
    end else begin
      stat_bits_reg <= (wr_clr ? 8'h00 : stat_bits_reg)
                       | evt_vec;
      if (sreq_fire) begin
        req_bit_reg <= 1'b1;
      end else if (wr_clr) begin
        req_bit_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // pulse timer: fixed count, gap cycle, re-arm
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pst_reg  <= espo_pkg::PST_IDLE;
      pcnt_reg <= 8'h0;
      pend_reg <= 1'b0;
    end else begin
      unique case (pst_reg)
        espo_pkg::PST_IDLE: begin
          pcnt_reg <= 8'h0;
          if (evt_sel) begin
            pst_reg <= espo_pkg::PST_HIGH;
          end
        end
        espo_pkg::PST_HIGH: begin
          pcnt_reg <= pcnt_reg + 8'h1;
          if (evt_sel) begin
            pend_reg <= 1'b1;
          end
          if (pcnt_reg == espo_pkg::PULSE_CYC - 8'h1) begin
            pst_reg <= espo_pkg::PST_GAP;
          end
        end
        espo_pkg::PST_GAP: begin
          // one idle cycle keeps back-to-back pulses apart
          pcnt_reg <= 8'h0;
          pend_reg <= 1'b0;
          pst_reg  <= (pend_reg || evt_sel) ? espo_pkg::PST_HIGH
                                            : espo_pkg::PST_IDLE;
        end
        default: begin
          pst_reg <= espo_pkg::PST_IDLE;
        end
      endcase
    end
  end

  // output pin: aperture follows converter level
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync_reg <= 1'b0;
    end else if (cfg_reg.src == espo_pkg::SRC_APERTURE) begin
      // busy covers autozero and autorange conversions too
      sync_reg <= i_aperture ^ cfg_reg.active_low_polarity;
    end else begin
      sync_reg <= (pst_reg == espo_pkg::PST_HIGH)
                  ^ cfg_reg.active_low_polarity;
    end
  end

  // ==========================================
  // external trigger with optional one-deep hold
  assign too_fast = i_ext_trig && i_rdg_busy
                    && !(cfg_reg.trigger_hold_enable && !held_reg);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      held_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else if (!i_rdg_busy) begin
      // a held trigger goes first, a new one is held behind it
      trig_reg <= held_reg || i_ext_trig;
      held_reg <= held_reg && i_ext_trig
                  && cfg_reg.trigger_hold_enable;
    end else begin
      trig_reg <= 1'b0;
      if (i_ext_trig && cfg_reg.trigger_hold_enable) begin
        held_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // interrupt status, write one to clear, set wins
  logic [2:0] ists_set;
  logic [2:0] ists_clr;
  assign ists_set = {grp_last, too_fast,
                     pst_reg != espo_pkg::PST_HIGH && evt_sel};
  assign ists_clr = (wr_fire && awaddr_reg == espo_pkg::OFS_ISTAT
                     && wstrb_reg[0]) ? wdata_reg[2:0] : 3'h0;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ists_reg <= 3'h0;
      irq_reg  <= 1'b0;
    end else begin
      ists_reg <= (ists_reg & ~ists_clr) | ists_set;
      irq_reg  <= |(ists_reg & imask_reg);
    end
  end

  // ==========================================
  // axi4-lite write channels, one write at a time
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_rdy_reg <= 1'b1;
      w_rdy_reg  <= 1'b1;
      awaddr_reg <= 8'h0;
      wdata_reg  <= 32'h0;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= espo_pkg::RESP_OKAY;
    end else begin
      if (aw_rdy_reg && i_awvalid) begin
        aw_rdy_reg <= 1'b0;
        awaddr_reg <= {i_awaddr[7:2], 2'h0};
      end
      if (w_rdy_reg && i_wvalid) begin
        w_rdy_reg <= 1'b0;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= espo_mapped(awaddr_reg) ? espo_pkg::RESP_OKAY
                                              : espo_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
        aw_rdy_reg <= 1'b1;
        w_rdy_reg  <= 1'b1;
      end
    end
  end

  // read channel, data registered with the valid
  logic [31:0] rd_mux;
  always_comb begin
    unique case ({i_araddr[7:2], 2'h0})
      espo_pkg::OFS_CFG:     rd_mux = {22'h0, pst_reg != espo_pkg::PST_IDLE,
                                       held_reg, 3'h0, cfg_reg};
      espo_pkg::OFS_GROUP:   rd_mux = {grp_cnt_reg, grp_size_reg};
      espo_pkg::OFS_REQMASK: rd_mux = {24'h0, req_mask_reg};
      espo_pkg::OFS_REQSTAT: rd_mux = {23'h0, req_bit_reg, stat_bits_reg};
      espo_pkg::OFS_ISTAT:   rd_mux = {29'h0, ists_reg};
      espo_pkg::OFS_IMASK:   rd_mux = {29'h0, imask_reg};
      default:               rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= espo_pkg::RESP_OKAY;
    end else if (ar_rdy_reg && i_arvalid) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= espo_mapped({i_araddr[7:2], 2'h0})
                    ? espo_pkg::RESP_OKAY : espo_pkg::RESP_SLVERR;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
      ar_rdy_reg <= 1'b1;
    end
  end

  // ==========================================
  // outputs, all straight from flops
  assign o_awready    = aw_rdy_reg;
  assign o_wready     = w_rdy_reg;
  assign o_bvalid     = bvalid_reg;
  assign o_bresp      = bresp_reg;
  assign o_arready    = ar_rdy_reg;
  assign o_rvalid     = rvalid_reg;
  assign o_rdata      = rdata_reg;
  assign o_rresp      = rresp_reg;
  assign o_sync_out   = sync_reg;
  assign o_trig_start = trig_reg;
  assign o_irq        = irq_reg;

  // ==========================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_read_pulse;
    pst_reg == espo_pkg::PST_IDLE && i_reading_done
      && cfg_reg.src == espo_pkg::SRC_READING
      |=> pst_reg == espo_pkg::PST_HIGH ##1 o_sync_out
      == !cfg_reg.active_low_polarity;
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("reading done did not start a pulse");

  property p_width;
    $rose(pst_reg == espo_pkg::PST_HIGH) |->
      ##249 pst_reg == espo_pkg::PST_HIGH ##1 pst_reg == espo_pkg::PST_GAP;
  endproperty
  a_width: assert property (p_width)
    else $error("pulse width not 250 cycles");

  property p_idle_level;
    pst_reg != espo_pkg::PST_HIGH && cfg_reg.src != espo_pkg::SRC_APERTURE
      |=> o_sync_out == $past(cfg_reg.active_low_polarity);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("sync output not at idle level");

  property p_aperture;
    cfg_reg.src == espo_pkg::SRC_APERTURE
      |=> o_sync_out == ($past(i_aperture) ^ $past(cfg_reg.active_low_polarity));
  endproperty
  a_aperture: assert property (p_aperture)
    else $error("aperture level not followed");

  property p_one_shot_off;
    cfg_reg.src == espo_pkg::SRC_ONE_SHOT && !wr_cfg
      |=> cfg_reg.src == espo_pkg::SRC_OFF;
  endproperty
  a_one_shot_off: assert property (p_one_shot_off)
    else $error("one-shot did not turn source off");

  property p_group_bound;
    grp_cnt_reg < grp_goal || !$stable(grp_size_reg);
  endproperty
  a_group_bound: assert property (p_group_bound)
    else $error("group count passed group size");

  property p_req_sticky;
    req_bit_reg && !wr_clr |=> req_bit_reg;
  endproperty
  a_req_sticky: assert property (p_req_sticky)
    else $error("request bit dropped without clear");

  property p_sreq_pulse;
    sreq_fire && cfg_reg.src == espo_pkg::SRC_SREQ
      && pst_reg == espo_pkg::PST_IDLE |=> pst_reg == espo_pkg::PST_HIGH;
  endproperty
  a_sreq_pulse: assert property (p_sreq_pulse)
    else $error("service request did not pulse");

  property p_hold;
    i_ext_trig && i_rdg_busy && cfg_reg.trigger_hold_enable && !held_reg
      |-> !too_fast ##1 held_reg;
  endproperty
  a_hold: assert property (p_hold)
    else $error("early trigger not held");

  c_back_to_back: cover property (pst_reg == espo_pkg::PST_GAP
    ##1 pst_reg == espo_pkg::PST_HIGH);
  c_one_shot: cover property (cfg_reg.src == espo_pkg::SRC_ONE_SHOT);
  c_group: cover property (grp_last && cfg_reg.src == espo_pkg::SRC_GROUP);
  c_held_go: cover property (held_reg && !i_rdg_busy ##1 trig_reg);
endmodule // espo_top

/* File: hdl/espo_pkg.sv */
// constants, types and register map of the sync pulse output block
package espo_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_NS   = 4;    // core clock period
  localparam int unsigned PULSE_NS = 1000; // sync pulse width
  localparam logic [7:0]  PULSE_CYC = 8'(PULSE_NS / CLK_NS);
  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFS_CFG     = 8'h00; // sync_output_config
  localparam logic [7:0] OFS_GROUP   = 8'h04; // readings_per_trigger
  localparam logic [7:0] OFS_REQMASK = 8'h08; // request_enable_mask
  localparam logic [7:0] OFS_REQSTAT = 8'h0c; // status + request bit
  localparam logic [7:0] OFS_CLRSTAT = 8'h10; // clear_status_cmd
  localparam logic [7:0] OFS_ISTAT   = 8'h14; // interrupt status w1c
  localparam logic [7:0] OFS_IMASK   = 8'h18; // interrupt mask
  // ==========================================
  // field positions and reset values
  localparam int unsigned REQ_BIT_POS  = 8;
  localparam int unsigned IRQ_PULSE    = 0;  // sync pulse started
  localparam int unsigned IRQ_TOO_FAST = 1;  // trigger too fast
  localparam int unsigned IRQ_GROUP    = 2;  // group finished
  localparam logic [15:0] GROUP_RST    = 16'h0001;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ==========================================
  // event source select
  typedef enum logic [2:0] {
    SRC_OFF      = 3'h0,
    SRC_READING  = 3'h1, // reading_done_source
    SRC_GROUP    = 3'h2, // group_done_source
    SRC_INTEG    = 3'h3, // integration_done_source
    SRC_APERTURE = 3'h4, // aperture_level_source
    SRC_SREQ     = 3'h5, // service request
    SRC_ONE_SHOT = 3'h6  // single software pulse
  } espo_src_e;
  // pulse timer states, gray along idle-high-gap
  typedef enum logic [1:0] {
    PST_IDLE = 2'h0,
    PST_HIGH = 2'h1,
    PST_GAP  = 2'h3
  } espo_pst_e;
  // sync_output_config layout
  typedef struct packed {
    logic      trigger_hold_enable; // bit 4
    logic      active_low_polarity; // bit 3
    espo_src_e src;                 // bits 2:0
  } espo_cfg_s;
  localparam espo_cfg_s CFG_RST = '{1'b0, 1'b0, SRC_OFF};
endpackage : espo_pkg

/* File: verif/espo_scanner.sv */
// scanner model that listens to the sync line and steps its channel
module espo_scanner (
  input  wire logic        i_clk,
  input  wire logic        i_sync,
  input  wire logic        i_active_low,
  input  wire logic        i_listen,
  output logic [15:0]      o_width,
  output logic             o_done,
  output logic             o_chan_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_reg = 16'h0000; // cycles seen at active level
  logic [1:0]  dly_reg = 2'h0;     // relay settle before closure
  // ==========================================
  // width counter, a pulse ends on return to idle
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (!i_listen) begin
      cnt_reg <= 16'h0000; // deaf while polarity changes
    end else if (i_sync ^ i_active_low) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end else if (cnt_reg != 16'h0000) begin
      o_width <= cnt_reg;
      o_done  <= 1'b1;
      cnt_reg <= 16'h0000;
    end
  end
  // ==========================================
  // channel closes three cycles after each step, retriggering the meter
  always_ff @(posedge i_clk) begin
    dly_reg       <= {dly_reg[0], o_done};
    o_chan_closed <= dly_reg[1];
  end
endmodule // espo_scanner

/* File: verif/espo_top_tb.sv */
// self-checking bench for the sync pulse output block
module espo_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // stimulus and observed signals
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic [7:0]  addr       = 8'h00;   // shared, one transfer at a time
  logic [31:0] wdata      = 32'h0;
  logic [9:0]  ev         = 10'h000; // {status, prog, integ, reading}
  logic        aperture   = 1'b0;
  logic        busy       = 1'b0;
  logic        pol        = 1'b0;    // idle level told to the scanner
  logic        listen     = 1'b0;
  logic        hold_busy  = 1'b0;    // pins the converter busy high
  logic        xtrig      = 1'b0;    // bench-made external trigger
  int          trig_cnt   = 0;       // trigger pulses seen
  int          trig_base  = 0;
  logic [7:0]  lfsr       = 8'h0e;
  logic        awready, wready, bvalid, arready, rvalid, trig, sync, irq;
  logic        sc_done, sc_trig;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] sc_width;
  logic [33:0] exp_bus[$];           // {resp, data} per bus answer
  logic [15:0] exp_w[$];             // widths of expected pulses
  int          num_errors  = 0;
  int          comparisons = 0;
  always #2 i_core_clk = ~i_core_clk;
  // ==========================================
  // design and far-side scanner
  espo_top dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(addr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(addr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_reading_done(ev[0]),
    .i_integ_done(ev[1]), .i_aperture(aperture), .i_prog_done(ev[2]),
    .i_status_evt(ev[9:3]), .i_ext_trig(sc_trig | xtrig), .i_rdg_busy(busy),
    .o_trig_start(trig), .o_sync_out(sync), .o_irq(irq));
  espo_scanner scanner (.i_clk(i_core_clk), .i_sync(sync), .i_active_low(pol),
    .i_listen(listen), .o_width(sc_width), .o_done(sc_done), .o_chan_closed(sc_trig));
  // ==========================================
  // helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [33:0] e, input logic [33:0] got);
    comparisons++;
    if (e !== got) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  // one axi4-lite transfer; the answer is compared by the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    int   n;
    logic a_ok;
    logic d_ok;
    exp_bus.push_back(e);
    n    = 0;
    a_ok = 1'b0;
    d_ok = !w;
    @(posedge i_core_clk);
    addr    <= a;
    wdata   <= d;
    awvalid <= w;
    wvalid  <= w;
    bready  <= w;
    arvalid <= !w;
    rready  <= !w;
    while (!(a_ok && d_ok) && n < 50) begin
      @(posedge i_core_clk);
      n++;
      if (!a_ok && (w ? awready : arready) === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (!d_ok && wready === 1'b1) begin
        d_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while ((w ? bvalid : rvalid) !== 1'b1 && n < 50) begin
      @(posedge i_core_clk);
      n++;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("MISMATCH bus answer expected response seen none");
    end
  endtask
  task automatic fire(input logic [9:0] m);
    @(posedge i_core_clk);
    ev <= m;
    @(posedge i_core_clk);
    ev <= 10'h000;
  endtask
  task automatic want;
    exp_w.push_back(16'(espo_pkg::PULSE_CYC));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // scanner deaf while the polarity flips, or it would see a false pulse
  task automatic cfg(input logic [31:0] d);
    listen <= 1'b0;
    bus(1'b1, espo_pkg::OFS_CFG, d, 34'h0);
    idle(3);
    pol    <= d[3];
    listen <= 1'b1;
    idle(1);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================
  // monitor: oldest note against each answer and each pulse
  always @(posedge i_core_clk) begin
    lfsr <= lfsr_next(lfsr);
    busy <= hold_busy | &lfsr[1:0]; // random converter busy level
    if (trig === 1'b1) begin
      trig_cnt++;
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check("write resp", exp_bus.size() ? exp_bus.pop_front() : 'x, {bresp, 32'h0});
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check("read data", exp_bus.size() ? exp_bus.pop_front() : 'x, {rresp, rdata});
    end
    if (sc_done === 1'b1) begin
      check("pulse width", {18'h0, exp_w.size() ? exp_w.pop_front() : 16'hxxxx},
            {18'h0, sc_width});
    end
  end
  initial begin
    idle(20000);
    num_errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    idle(12);
    i_rst  <= 1'b0;
    listen <= 1'b1;
    bus(1'b0, espo_pkg::OFS_CFG, 32'h0, 34'h0);
    bus(1'b0, espo_pkg::OFS_GROUP, 32'h0, 34'h1);
    bus(1'b0, 8'h1c, 32'h0, {espo_pkg::RESP_SLVERR, 32'h0});
    bus(1'b1, 8'h1c, 32'h1, {espo_pkg::RESP_SLVERR, 32'h0});
    $display("test registers done");
    cfg(32'h1);
    want();
    fire(10'h001);
    fire(10'h002);
    idle(300);
    want();
    want();
    fire(10'h001);
    idle(2);
    fire(10'h001);
    idle(600);
    $display("test reading source done");
    cfg(32'h0b);
    check("idle level", 34'h1, {33'h0, sync});
    want();
    fire(10'h002);
    fire(10'h001);
    idle(300);
    cfg(32'h0);
    $display("test integration source done");
    bus(1'b1, espo_pkg::OFS_GROUP, 32'h3, 34'h0);
    cfg(32'h2);
    want();
    repeat (5) begin
      fire(10'h001);
      idle(8);
    end
    idle(300);
    bus(1'b0, espo_pkg::OFS_GROUP, 32'h0, 34'h0_0002_0003);
    $display("test group source done");
    bus(1'b1, espo_pkg::OFS_REQMASK, 32'h2, 34'h0);
    cfg(32'h5);
    want();
    fire(10'h008);
    idle(300);
    want();
    fire(10'h008);
    idle(300);
    fire(10'h010);
    bus(1'b0, espo_pkg::OFS_REQSTAT, 32'h0, 34'h106);
    bus(1'b1, espo_pkg::OFS_CLRSTAT, 32'h1, 34'h0);
    bus(1'b0, espo_pkg::OFS_REQSTAT, 32'h0, 34'h0);
    bus(1'b1, espo_pkg::OFS_REQMASK, 32'h1, 34'h0);
    want();
    fire(10'h004);
    idle(300);
    bus(1'b0, espo_pkg::OFS_REQSTAT, 32'h0, 34'h101);
    $display("test service request done");
    bus(1'b1, espo_pkg::OFS_IMASK, 32'h1, 34'h0);
    idle(2);
    check("irq raised", 34'h1, {33'h0, irq});
    bus(1'b1, espo_pkg::OFS_ISTAT, 32'h1, 34'h0);
    idle(2);
    check("irq cleared", 34'h0, {33'h0, irq});
    $display("test interrupt done");
    want();
    bus(1'b1, espo_pkg::OFS_CFG, 32'h6, 34'h0);
    idle(300);
    bus(1'b0, espo_pkg::OFS_CFG, 32'h0, 34'h0);
    $display("test one-shot done");
    cfg(32'h4);
    exp_w.push_back(16'd20);
    aperture <= 1'b1;
    idle(20);
    aperture <= 1'b0;
    idle(10);
    check("pulses left", 34'h0, 34'(exp_w.size()));
    $display("test aperture done");
    hold_busy <= 1'b1;
    cfg(32'h10);
    trig_base = trig_cnt;
    xtrig <= 1'b1;
    idle(1);
    xtrig <= 1'b0;
    idle(2);
    bus(1'b0, espo_pkg::OFS_CFG, 32'h0, 34'h110);
    hold_busy <= 1'b0;
    idle(40);
    bus(1'b0, espo_pkg::OFS_CFG, 32'h0, 34'h10);
    check("held trigger", 34'h1, 34'(trig_cnt - trig_base));
    $display("test trigger hold done");
    wrap_up();
  end
endmodule // espo_top_tb
